// ### design/hub_strap_defs.svh
// Constants for the strap capture and pin function block
`ifndef HUB_STRAP_DEFS_SVH
`define HUB_STRAP_DEFS_SVH
// Number of downstream ports
`define PORT_COUNT        2
// Width of the non-removable port count field
`define FIXED_CNT_W       2
// Nanoseconds the straps are held still before capture after reset release
`define STRAP_SETTLE_NS   40
`define CLK_PERIOD_NS     4
`define STRAP_SETTLE_CYC  ((`STRAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Counter width for settle timing
`define SETTLE_CNT_W      4
// Reset values of captured configuration
`define RST_SHARED_POWER  1'b0
`define RST_CHARGE_EN     1'b0
`define RST_FIXED_COUNT   2'h0
`endif

// ### design/hub_strap_pkg.sv
// Types for the strap capture and pin function block
package hub_strap_pkg;
  // Function of the shared serial configuration pins
  typedef enum logic [1:0] {
    PINS_RESET = 2'b00,
    PINS_ROM   = 2'b01,
    PINS_SLAVE = 2'b10
  } pin_mode_t;
  // Capture sequence
  typedef enum logic [1:0] {
    SEQ_HOLD   = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_RUN    = 2'b10
  } seq_state_t;
endpackage

// ### design/sync_two_ff.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;  // First stage, read only by second

  // Two stages in series
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule // sync_two_ff

// ### design/hub_strap_and_pin_function_ctrl.sv
// Strap capture and shared pin steering for a two-port hub
`timescale 1ns/1ps
`include "hub_strap_defs.svh"

// What this block does
// - Capture straps at power-on and reset release
// - Drive power pin high to power port
// - Input power pin reports port overcurrent
// - ROM select low selects, high deselects
// - Clock pin: ROM clock or open-drain clock
// - Data pin: ROM data out or bidirectional
// - Sample ROM data; pin is charge strap
// - Stay in reset while external reset low
// - Shared power strap high enables ganged mode
// - Fixed port count from strap value
// - Charging enabled only by strap level
// - Pull-ups on both pins select slave mode
// - No pulls on pins selects ROM mode
module hub_strap_and_pin_function_ctrl (
  // Clock and power-on reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // External active-low reset pin
  input  wire logic                     resetPin_n,
  // Port power pins, two-way
  input  wire logic [`PORT_COUNT-1:0]   portPowerIn,
  output logic      [`PORT_COUNT-1:0]   portPowerOut,
  output logic      [`PORT_COUNT-1:0]   portPowerOe,
  // Shared power strap pin, two-way
  input  wire logic                     sharedPowerIn,
  output logic                          sharedPowerOut,
  output logic                          sharedPowerOe,
  // ROM select pin, also fixed port count strap
  input  wire logic [`FIXED_CNT_W-1:0]  fixedPortCountStrap,
  output logic                          romSelect_n,
  output logic                          romSelectOe,
  // ROM data in pin, also charge enable strap
  input  wire logic                     romDataIn,
  // Shared clock pin
  input  wire logic                     smClockPinIn,
  output logic                          smClockPinOut,
  output logic                          smClockPinOe,
  // Shared data pin
  input  wire logic                     smDataPinIn,
  output logic                          smDataPinOut,
  output logic                          smDataPinOe,
  // Pull-up sense from the pad ring during reset
  input  wire logic                     clockPullUpSense,
  input  wire logic                     dataPullUpSense,
  // Internal ROM master side
  input  wire logic                     romSelReq,
  input  wire logic                     romClockReq,
  input  wire logic                     romDataReq,
  output logic                          romDataSample,
  // Internal slave side, high means pull the line low
  input  wire logic                     slaveClockLow,
  input  wire logic                     slaveDataLow,
  output logic                          slaveClockSample,
  output logic                          slaveDataSample,
  // Port power requests from hub logic
  input  wire logic [`PORT_COUNT-1:0]   portPowerReq,
  output logic      [`PORT_COUNT-1:0]   overCurrent,
  // Captured configuration and status
  output logic                          inReset,
  output hub_strap_pkg::pin_mode_t      pinMode,
  output logic                          gangPowerMode,
  output logic      [`FIXED_CNT_W-1:0]  fixedPortCount,
  output logic                          chargeEnable
);
  import hub_strap_pkg::*;

  localparam int PINS = `PORT_COUNT + `FIXED_CNT_W + 7;

  // Synchronised pin levels
  logic [PINS-1:0]        pinsSync;
  logic                   rstSync_n;      // External reset, synchronised
  logic [`PORT_COUNT-1:0] powerSync;      // Port power pin levels
  logic                   sharedSync;     // Shared power pin level
  logic [`FIXED_CNT_W-1:0] fixedSync;     // Fixed count strap
  logic                   romDiSync;      // ROM data / charge strap
  logic                   clkPinSync;     // Shared clock pin
  logic                   datPinSync;     // Shared data pin
  logic                   clkPullSync;    // Clock pull-up sensed
  logic                   datPullSync;    // Data pull-up sensed

  // Capture sequence state
  seq_state_t              seq_q;
  logic [`SETTLE_CNT_W-1:0] settle_q;     // Settle counter
  logic                    capture;       // One-cycle strap capture

  // Every pin passes two flip-flops before use
  sync_two_ff #(
    .WIDTH (PINS)
  ) u_pinSync (
    .clk     (clk),
    .srst    (srst),
    .asyncIn ({resetPin_n, portPowerIn, sharedPowerIn,
               fixedPortCountStrap, romDataIn, smClockPinIn,
               smDataPinIn, clockPullUpSense, dataPullUpSense}),
    .syncOut (pinsSync)
  );

  // Split synchronised vector
  assign {rstSync_n, powerSync, sharedSync, fixedSync, romDiSync,
          clkPinSync, datPinSync, clkPullSync, datPullSync} = pinsSync;

  // Capture sequence: hold, settle, run
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_q    <= SEQ_HOLD;
      settle_q <= '0;
    end else begin
      case (seq_q)
        SEQ_HOLD: begin
          // remain held while reset pin low
          settle_q <= '0;
          if (rstSync_n) begin
            seq_q <= SEQ_SETTLE;
          end
        end
        SEQ_SETTLE: begin
          // Back to hold if reset pin drops
          if (!rstSync_n) begin
            seq_q <= SEQ_HOLD;
          end else if (settle_q ==
                       `SETTLE_CNT_W'(`STRAP_SETTLE_CYC - 1)) begin
            seq_q <= SEQ_RUN;
          end else begin
            settle_q <= settle_q + `SETTLE_CNT_W'(1);
          end
        end
        SEQ_RUN: begin
          if (!rstSync_n) begin
            seq_q <= SEQ_HOLD;
          end
        end
        default: begin
          seq_q <= SEQ_HOLD;
        end
      endcase
    end
  end

  // capture at end of settle after release
  assign capture = (seq_q == SEQ_SETTLE) && rstSync_n &&
                   (settle_q == `SETTLE_CNT_W'(`STRAP_SETTLE_CYC - 1));

  // Reset mode status
  always_ff @(posedge clk) begin
    if (srst) begin
      inReset <= 1'b1;
    end else begin
      inReset <= !(seq_q == SEQ_RUN && rstSync_n) && !capture;
    end
  end

  // Captured strap values
  always_ff @(posedge clk) begin
    if (srst) begin
      pinMode        <= PINS_RESET;
      gangPowerMode  <= `RST_SHARED_POWER;
      fixedPortCount <= `RST_FIXED_COUNT;
      chargeEnable   <= `RST_CHARGE_EN;
    end else if (capture) begin
      // gang mode when shared strap high
      gangPowerMode  <= sharedSync;
      fixedPortCount <= fixedSync;
      chargeEnable   <= romDiSync;
      // both pulled up selects slave mode
      if (clkPullSync && datPullSync) begin
        pinMode <= PINS_SLAVE;
      end else begin
        pinMode <= PINS_ROM;
      end
    end else if (seq_q == SEQ_HOLD || !rstSync_n) begin
      // Pins released while reset held
      pinMode <= PINS_RESET;
    end
  end

  // Shared serial pin drive
  always_ff @(posedge clk) begin
    if (srst) begin
      romSelect_n   <= 1'b1;
      romSelectOe   <= 1'b0;
      smClockPinOut <= 1'b0;
      smClockPinOe  <= 1'b0;
      smDataPinOut  <= 1'b0;
      smDataPinOe   <= 1'b0;
    end else begin
      // release shared pins as reset pin drops
      case (rstSync_n ? pinMode : PINS_RESET)
        PINS_ROM: begin
          romSelect_n   <= !romSelReq;
          romSelectOe   <= 1'b1;
          smClockPinOut <= romClockReq;
          smClockPinOe  <= 1'b1;
          smDataPinOut  <= romDataReq;
          smDataPinOe   <= 1'b1;
        end
        PINS_SLAVE: begin
          // Select pin is a strap only here
          romSelect_n   <= 1'b1;
          romSelectOe   <= 1'b0;
          smClockPinOut <= 1'b0;
          smClockPinOe  <= slaveClockLow;
          smDataPinOut  <= 1'b0;
          smDataPinOe   <= slaveDataLow;
        end
        default: begin
          romSelect_n   <= 1'b1;
          romSelectOe   <= 1'b0;
          smClockPinOut <= 1'b0;
          smClockPinOe  <= 1'b0;
          smDataPinOut  <= 1'b0;
          smDataPinOe   <= 1'b0;
        end
      endcase
    end
  end

  // Samples of the shared pins
  always_ff @(posedge clk) begin
    if (srst) begin
      romDataSample    <= 1'b0;
      slaveClockSample <= 1'b1;
      slaveDataSample  <= 1'b1;
    end else begin
      // ROM data sampled in ROM mode only
      romDataSample    <= (pinMode == PINS_ROM) ? romDiSync : 1'b0;
      slaveClockSample <= (pinMode == PINS_SLAVE) ? clkPinSync : 1'b1;
      slaveDataSample  <= (pinMode == PINS_SLAVE) ? datPinSync : 1'b1;
    end
  end

  // Port power drive and overcurrent sense
  always_ff @(posedge clk) begin
    if (srst) begin
      portPowerOut   <= '0;
      portPowerOe    <= '0;
      sharedPowerOut <= 1'b0;
      sharedPowerOe  <= 1'b0;
      overCurrent    <= '0;
    end else if (seq_q != SEQ_RUN || !rstSync_n) begin
      // Pins float as straps in reset
      portPowerOut   <= '0;
      portPowerOe    <= '0;
      sharedPowerOut <= 1'b0;
      sharedPowerOe  <= 1'b0;
      overCurrent    <= '0;
    end else if (gangPowerMode) begin
      // one shared pin powers all ports
      sharedPowerOut <= |portPowerReq;
      sharedPowerOe  <= |portPowerReq;
      portPowerOut   <= '0;
      portPowerOe    <= '0;
      overCurrent    <= {`PORT_COUNT{!(|portPowerReq) && sharedSync}};
    end else begin
      portPowerOut   <= portPowerReq;
      portPowerOe    <= portPowerReq;
      sharedPowerOut <= 1'b0;
      sharedPowerOe  <= 1'b0;
      overCurrent    <= ~portPowerReq & powerSync;
    end
  end
endmodule // hub_strap_and_pin_function_ctrl

// ### tb/hub_strap_properties.sv
// Port-level checker for the strap and pin block
`timescale 1ns/1ps
module hub_strap_checker (
  // Clock and resets
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       resetPin_n,
  // Port power
  input wire logic [1:0] portPowerReq,
  input wire logic [1:0] portPowerOut,
  input wire logic [1:0] portPowerOe,
  input wire logic       sharedPowerOut,
  input wire logic       sharedPowerOe,
  // Shared configuration pins
  input wire logic       romSelReq,
  input wire logic       romSelect_n,
  input wire logic       romSelectOe,
  input wire logic       romClockReq,
  input wire logic       smClockPinOut,
  input wire logic       smClockPinOe,
  input wire logic       smDataPinOe,
  input wire logic       slaveClockLow,
  // Status and straps
  input wire logic       inReset,
  input wire hub_strap_pkg::pin_mode_t pinMode,
  input wire logic       gangPowerMode,
  input wire logic [1:0] fixedPortCount,
  input wire logic       chargeEnable
);
  import hub_strap_pkg::*;
  // One clock domain, power-on reset disables
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_reset_idle: assert property (
    inReset |-> !smClockPinOe && !smDataPinOe && !(|portPowerOe) && romSelect_n)
    else $error("pins driven in reset mode");
  chk_pin_reset: assert property (
    !resetPin_n [*4] |-> inReset && pinMode == PINS_RESET)
    else $error("reset pin low but not in reset mode");
  chk_capture_time: assert property (
    $rose(resetPin_n) |-> ##[8:16] !inReset)
    else $error("no capture after reset pin release");
  chk_straps_hold: assert property (
    !inReset && $past(!inReset) |->
      $stable({gangPowerMode, fixedPortCount, chargeEnable}))
    else $error("captured strap moved between resets");
  chk_power_follow: assert property (
    !inReset && $past(!inReset) && $past(!inReset, 2) && !gangPowerMode |->
      portPowerOe == $past(portPowerReq)
      && (portPowerOut & portPowerOe) == portPowerOe)
    else $error("port power drive wrong");
  chk_rom_select: assert property (
    pinMode == PINS_ROM && $past(pinMode) == PINS_ROM |->
      romSelectOe && romSelect_n == !$past(romSelReq))
    else $error("rom select level wrong");
  chk_rom_clock: assert property (
    pinMode == PINS_ROM && $past(pinMode) == PINS_ROM |->
      smClockPinOe && smClockPinOut == $past(romClockReq))
    else $error("rom clock not driven");
  chk_slave_clock: assert property (
    pinMode == PINS_SLAVE && $past(pinMode) == PINS_SLAVE |->
      smClockPinOe == $past(slaveClockLow) && !(smClockPinOe && smClockPinOut))
    else $error("slave clock not open drain");
  chk_gang_drive: assert property (
    (gangPowerMode && !inReset && |portPowerReq) [*3] |->
      sharedPowerOe && sharedPowerOut)
    else $error("gang power pin not driven");
  // Main scenarios reached
  cover property (pinMode == PINS_ROM && smClockPinOe);
  cover property (pinMode == PINS_SLAVE && smClockPinOe);
  cover property (gangPowerMode && sharedPowerOe);
endmodule // hub_strap_checker

bind hub_strap_and_pin_function_ctrl hub_strap_checker u_hub_strap_checker (.*);

// ### tb/hub_pin_partner.sv
// Board model: pulls, strap resistors, ROM, current monitors
`timescale 1ns/1ps
module hub_pin_partner (
  // Clock and bench controls
  input  wire logic       clk,
  input  wire logic       pullUps,
  input  wire logic       chargeStrap,
  input  wire logic       gangStrap,
  input  wire logic       hostDataLow,
  input  wire logic [1:0] ocFault,
  // Device drives
  input  wire logic       romSelect_n,
  input  wire logic       romSelectOe,
  input  wire logic       smClockPinOut,
  input  wire logic       smClockPinOe,
  input  wire logic       smDataPinOut,
  input  wire logic       smDataPinOe,
  input  wire logic       sharedPowerOut,
  input  wire logic       sharedPowerOe,
  input  wire logic [1:0] portPowerOut,
  input  wire logic [1:0] portPowerOe,
  // Wire levels back
  output logic            smClockPinIn,
  output logic            smDataPinIn,
  output logic            romDataIn,
  output logic            sharedPowerIn,
  output logic [1:0]      portPowerIn,
  output logic            clockPullUpSense,
  output logic            dataPullUpSense
);
  logic tog = 1'b0; // Floating pins wander
  // Changes every cycle
  always @(posedge clk) tog <= ~tog;
  assign clockPullUpSense = pullUps;
  assign dataPullUpSense  = pullUps;
  // clock wire, pulled or floating when released
  assign smClockPinIn = smClockPinOe ? smClockPinOut : (pullUps | tog);
  // data wire, host may pull it low
  assign smDataPinIn = (smDataPinOe ? smDataPinOut : (pullUps | tog))
                       & ~hostDataLow;
  // ROM returns inverted data when selected
  assign romDataIn = (romSelectOe & ~romSelect_n) ? ~smDataPinOut
                                                  : chargeStrap;
  // monitor raises an undriven pin on fault
  assign portPowerIn = (portPowerOe & portPowerOut) | (~portPowerOe & ocFault);
  assign sharedPowerIn = sharedPowerOe ? sharedPowerOut : gangStrap;
endmodule // hub_pin_partner

// ### tb/tb.sv
// Self-checking bench for the strap and pin block
`timescale 1ns/1ps
module tb;
  import hub_strap_pkg::*;
  // Clock, resets and board controls
  logic       clk, srst, resetPin_n, pullUps, chargeStrap, gangStrap;
  logic       hostDataLow, romDataIn, romDataSample, inReset;
  logic [1:0] ocFault, fixedPortCountStrap, portPowerReq, fixedPortCount;
  logic [1:0] portPowerIn, portPowerOut, portPowerOe, overCurrent;
  logic       sharedPowerIn, sharedPowerOut, sharedPowerOe;
  logic       romSelect_n, romSelectOe, romSelReq, romClockReq, romDataReq;
  logic       smClockPinIn, smClockPinOut, smClockPinOe, slaveClockLow;
  logic       smDataPinIn, smDataPinOut, smDataPinOe, slaveDataLow;
  logic       clockPullUpSense, dataPullUpSense, gangPowerMode;
  logic       slaveClockSample, slaveDataSample, chargeEnable;
  pin_mode_t  pinMode;
  int         checkCount = 0;
  int         nMismatch = 0;
  int         cycles = 0;

  hub_strap_and_pin_function_ctrl u_hub_strap_and_pin_function_ctrl (.*);
  hub_pin_partner u_hub_pin_partner (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      nMismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Set straps, release resets, wait for capture
  task automatic settle(input logic pu, cs, gs, input logic [1:0] fx);
    int k = 0;
    {pullUps, chargeStrap, gangStrap, fixedPortCountStrap} = {pu, cs, gs, fx};
    srst = 1'b0;
    resetPin_n = 1'b1;
    while (inReset !== 1'b0 && k < 40) begin
      wcyc(1);
      k++;
    end
    chk({6'h0, pinMode}, {6'h0, pu ? PINS_SLAVE : PINS_ROM});
    chk({gangPowerMode, chargeEnable, fixedPortCount}, {4'h0, gs, cs, fx});
  endtask
  // ROM pins, returned data, port power and overcurrent
  task automatic t_rom;
    romSelReq = 1'b1;
    romClockReq = 1'b1;
    wcyc(6);
    chk({romSelect_n, romSelectOe, smClockPinOut}, 8'h3);
    chk({smClockPinOe, smDataPinOut, smDataPinOe, romDataSample}, 8'hb);
    romDataReq = 1'b1;
    wcyc(6);
    chk({smDataPinOut, romDataSample}, 8'h2);
    romSelReq = 1'b0;
    portPowerReq = 2'b01;
    wcyc(6);
    chk(romSelect_n, 8'h1);
    chk({portPowerOe, portPowerOut[0], overCurrent[1]}, 8'h6);
    ocFault = 2'b10;
    wcyc(6);
    chk(overCurrent[1], 8'h1);
    {ocFault, portPowerReq, romDataReq} = '0;
    $display("t_rom done");
  endtask
  // Slave pins, gang power, straps held after capture
  task automatic t_slave;
    resetPin_n = 1'b0;
    wcyc(4);
    chk(inReset, 8'h1);
    settle(1'b1, 1'b0, 1'b1, 2'h1);
    {slaveClockLow, slaveDataLow, portPowerReq} = 4'b1110;
    wcyc(6);
    chk({smClockPinOe, smClockPinOut, slaveClockSample}, 8'h4);
    chk({smDataPinOe, smDataPinOut, slaveDataSample}, 8'h4);
    chk({sharedPowerOe, sharedPowerOut}, 8'h3);
    {slaveClockLow, slaveDataLow, hostDataLow} = 3'b001;
    {chargeStrap, fixedPortCountStrap} = 3'b111;
    wcyc(6);
    chk({smClockPinOe, slaveClockSample, smDataPinOe, slaveDataSample}, 8'h4);
    chk({gangPowerMode, chargeEnable, fixedPortCount}, 8'h9);
    {hostDataLow, portPowerReq} = '0;
    $display("t_slave done");
  endtask
  // Power-on reset in mid-run clears and recaptures
  task automatic t_por;
    srst = 1'b1;
    wcyc(3);
    chk({inReset, gangPowerMode, chargeEnable, fixedPortCount}, 8'h10);
    settle(1'b0, 1'b1, 1'b0, 2'h3);
    $display("t_por done");
  endtask
  // Main sequence
  initial begin
    {srst, resetPin_n, pullUps, chargeStrap, gangStrap} = 5'b11010;
    {ocFault, fixedPortCountStrap, portPowerReq} = 6'h08;
    {romSelReq, romClockReq, romDataReq, hostDataLow} = '0;
    {slaveClockLow, slaveDataLow} = '0;
    wcyc(12);
    settle(1'b0, 1'b1, 1'b0, 2'h2);
    t_rom();
    t_slave();
    t_por();
    tally_and_finish();
  end
endmodule // tb
